// ---- logic/ssf_pkg.sv ----
// constants and carrier types for the serial bus status flags
package ssf_pkg;

  // ==========================================================
  // register map
  localparam logic [15:0] BUS_STATUS_ADDR = 16'hFF79;
  localparam logic [7:0] BUS_STATUS_RESET = 8'h00;

  // ==========================================================
  // status bit positions
  localparam int unsigned MASTER_BIT = 7;
  localparam int unsigned ARB_LOST_BIT = 6;
  localparam int unsigned EXT_CODE_BIT = 5;
  localparam int unsigned ADDR_MATCH_BIT = 4;
  localparam int unsigned DIRECTION_BIT = 3;
  localparam logic [2:0] ARB_LOST_IDX = 3'h6;

  // ==========================================================
  // companion control register bit positions
  localparam int unsigned ENABLE_BIT = 7;
  localparam int unsigned RELEASE_BIT = 6;
  localparam int unsigned WAIT_RELEASE_BIT = 5;

  // ==========================================================
  // byte framing
  localparam logic [3:0] BIT_COUNT_RESET = 4'h0;
  localparam logic [3:0] EIGHTH_CLOCK = 4'h8;
  localparam logic [3:0] NINTH_CLOCK = 4'h9;
  localparam logic [3:0] EXT_CODE_LOW = 4'h0;
  localparam logic [3:0] EXT_CODE_HIGH = 4'hF;

  // ==========================================================
  // status register image, upper five bits held here
  typedef struct packed {
    logic master;
    logic arbLost;
    logic extCode;
    logic addrMatch;
    logic direction;
    logic [2:0] other;
  } ssf_status_t;

  // one cpu access
  typedef struct packed {
    logic [15:0] addr;
    logic rd;
    logic bitOp;
    logic [2:0] bitIdx;
  } ssf_cpu_req_t;

endpackage

// ---- logic/ssf_status_flags.sv ----
// status flag register of the two-wire bus controller
//
// Notes on behaviour
// - 8-bit read-only status register, reset to 00, byte or single-bit access.
// - master flag is 0 as slave or idle, 1 during master transmission.
// - master flag set while generating a start condition.
// - master flag cleared on stop, arbitration loss, bus release, enable falling, reset.
// - arbitration-lost flag set on lost arbitration; master flag cleared with it.
// - arbitration-lost flag cleared after status read, enable falling, reset.
// - single-bit operation on any other status bit clears arbitration-lost flag.
// - extension-code flag set at 8th clock rise if address top nibble is 0000/1111.
// - extension and match flags cleared on start, stop, release, enable falling, reset.
// - address-match flag set at 8th clock rise when address equals own address.
// - direction flag 0: receive, data line left floating.
// - direction flag 1: drive shift-out latch from 9th clock fall of first byte.
// - master generating start sets direction flag.
// - slave sets direction flag when first byte LSB is 1.
// - master sending 1 as first byte LSB clears direction flag.
// - wait release at 9th clock with direction 1 clears it and floats data line.
// - control bit 7 is interface enable, bit 6 is bus release.
`timescale 1ns/1ps

module ssf_status_flags
  import ssf_pkg::*;
(
  input wire logic clock, // controller clock, 200 MHz
  input wire logic rst_n, // synchronous reset, active low
  input wire logic serialClock, // serial_clock_pin, link clock
  input wire logic serialDataIn, // serial_data_pin level
  output logic serialDataOut, // serial_data_pin drive value
  output logic serialDataOe, // serial_data_pin drive enable
  input wire ssf_cpu_req_t cpuReq, // cpu read or bit operation
  input wire logic cpuWr, // cpu write, changes no flag but masks a read in the same cycle
  output logic [7:0] cpuRdData, // read data, held until next read
  input wire logic [7:0] busControlReg, // bus_control_reg contents
  input wire logic [7:0] ownSlaveAddress, // own_slave_address
  input wire logic startGen, // controller is generating a start
  input wire logic arbLostEvt, // one-cycle pulse, arbitration lost
  input wire logic shiftOutBit, // shift-out latch value
  output ssf_status_t busStatus // bus_status image
);

  function automatic logic rose(input logic prev, input logic cur);
    rose = cur & ~prev;
  endfunction

  function automatic logic fell(input logic prev, input logic cur);
    fell = prev & ~cur;
  endfunction

  // one address decode shared by reads and bit operations
  function automatic logic status_hit(input logic [15:0] addr);
    status_hit = (addr == BUS_STATUS_ADDR);
  endfunction

  function automatic logic ext_code(input logic [3:0] nibble);
    ext_code = (nibble == EXT_CODE_LOW) | (nibble == EXT_CODE_HIGH);
  endfunction

  // ==========================================================
  // link domain: sample data on every serial clock rise
  // the serial clock may stop between frames, so this side only
  // captures bits; all framing lives in the controller domain
  logic linkRst1_reg;
  logic linkRst2_reg;
  logic linkBit_reg;
  logic linkTog_reg;

  always_ff @(posedge serialClock) begin
    linkRst1_reg <= rst_n;
    linkRst2_reg <= linkRst1_reg;
  end

  always_ff @(posedge serialClock) begin
    if (!linkRst2_reg) begin
      linkBit_reg <= 1'b0;
      linkTog_reg <= 1'b0;
    end else begin
      linkBit_reg <= serialDataIn;
      linkTog_reg <= ~linkTog_reg;
    end
  end

  // ==========================================================
  // synchronisers into the controller domain
  logic sdaSync1_reg;
  logic sdaSync2_reg;
  logic sdaLast_reg;
  logic sclSync1_reg;
  logic sclSync2_reg;
  logic sclLast_reg;
  logic togSync1_reg;
  logic togSync2_reg;
  logic togLast_reg;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      sdaSync1_reg <= 1'b1;
      sdaSync2_reg <= 1'b1;
      sdaLast_reg <= 1'b1;
      sclSync1_reg <= 1'b1;
      sclSync2_reg <= 1'b1;
      sclLast_reg <= 1'b1;
      togSync1_reg <= 1'b0;
      togSync2_reg <= 1'b0;
      togLast_reg <= 1'b0;
    end else begin
      sdaSync1_reg <= serialDataIn;
      sdaSync2_reg <= sdaSync1_reg;
      sdaLast_reg <= sdaSync2_reg;
      sclSync1_reg <= serialClock;
      sclSync2_reg <= sclSync1_reg;
      sclLast_reg <= sclSync2_reg;
      togSync1_reg <= linkTog_reg;
      togSync2_reg <= togSync1_reg;
      togLast_reg <= togSync2_reg;
    end
  end

  // ==========================================================
  // bus events
  logic bitStrobe;
  logic startDet;
  logic stopDet;
  logic sclFall;

  assign bitStrobe = togSync2_reg ^ togLast_reg;
  assign startDet = sclSync2_reg & sclLast_reg & fell(sdaLast_reg, sdaSync2_reg);
  assign stopDet = sclSync2_reg & sclLast_reg & rose(sdaLast_reg, sdaSync2_reg);
  assign sclFall = fell(sclLast_reg, sclSync2_reg);

  // ==========================================================
  // control register edges
  logic enablePrev_reg;
  logic releasePrev_reg;
  logic waitPrev_reg;
  logic enabled;
  logic enableFall;
  logic releaseSet;
  logic waitReleaseSet;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      enablePrev_reg <= 1'b0;
      releasePrev_reg <= 1'b0;
      waitPrev_reg <= 1'b0;
    end else begin
      enablePrev_reg <= busControlReg[ENABLE_BIT];
      releasePrev_reg <= busControlReg[RELEASE_BIT];
      waitPrev_reg <= busControlReg[WAIT_RELEASE_BIT];
    end
  end

  assign enabled = busControlReg[ENABLE_BIT];
  assign enableFall = fell(enablePrev_reg, busControlReg[ENABLE_BIT]);
  assign releaseSet = rose(releasePrev_reg, busControlReg[RELEASE_BIT]);
  assign waitReleaseSet = rose(waitPrev_reg, busControlReg[WAIT_RELEASE_BIT]);

  // ==========================================================
  // byte framing: count clocks from start, keep the first byte
  logic [3:0] bitCount_reg;
  logic firstByte_reg;
  logic inFrame_reg;
  logic [6:0] shift_reg;
  logic [7:0] rxByte;
  logic addrDone;
  logic inNinth;
  logic atNinth;

  // linkBit_reg holds for a whole serial clock period, far longer than
  // the two-stage toggle sync, so it is settled whenever bitStrobe is high
  assign rxByte = {shift_reg, linkBit_reg};
  assign addrDone = bitStrobe & firstByte_reg & (bitCount_reg == EIGHTH_CLOCK - 4'h1);
  assign inNinth = inFrame_reg & (bitCount_reg == NINTH_CLOCK);
  assign atNinth = firstByte_reg & inNinth;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      bitCount_reg <= BIT_COUNT_RESET;
      firstByte_reg <= 1'b0;
      shift_reg <= 7'h00;
    end else if (startDet) begin
      bitCount_reg <= BIT_COUNT_RESET;
      firstByte_reg <= 1'b1;
    end else if (stopDet) begin
      bitCount_reg <= BIT_COUNT_RESET;
      firstByte_reg <= 1'b0;
    end else if (bitStrobe) begin
      shift_reg <= rxByte[6:0];
      if (bitCount_reg == NINTH_CLOCK) begin
        bitCount_reg <= 4'h1;
        firstByte_reg <= 1'b0;
      end else begin
        bitCount_reg <= bitCount_reg + 4'h1;
      end
    end
  end

  // stray clocks outside a frame must not look like a ninth clock
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      inFrame_reg <= 1'b0;
    end else if (startDet) begin
      inFrame_reg <= 1'b1;
    end else if (stopDet | enableFall) begin
      inFrame_reg <= 1'b0;
    end
  end

  // ==========================================================
  // cpu access; writes are ignored on purpose
  logic statusRead;
  logic otherBitOp;

  assign statusRead = cpuReq.rd & status_hit(cpuReq.addr) & ~cpuWr;
  assign otherBitOp = cpuReq.bitOp & status_hit(cpuReq.addr) & (cpuReq.bitIdx != ARB_LOST_IDX);

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      cpuRdData <= BUS_STATUS_RESET;
    end else if (statusRead) begin
      cpuRdData <= busStatus;
    end
  end

  // ==========================================================
  // flags; a set in the same cycle as a clear wins
  logic masterFlag_reg;
  logic arbLostFlag_reg;
  logic extCodeFlag_reg;
  logic addrMatchFlag_reg;
  logic directionFlag_reg;
  logic masterSet;
  logic masterClr;
  logic dirSet;
  logic dirClr;
  logic frameClr;
  logic extHit;
  logic ownHit;

  // one flop per flag, so each has a single driver; the low three bits
  // belong to flags kept elsewhere and read as zero here
  assign busStatus = '{master: masterFlag_reg, arbLost: arbLostFlag_reg, extCode: extCodeFlag_reg,
    addrMatch: addrMatchFlag_reg, direction: directionFlag_reg, other: 3'h0};

  assign masterSet = enabled & startGen;
  assign masterClr = stopDet | arbLostEvt | releaseSet | enableFall;
  assign frameClr = startDet | stopDet | releaseSet | enableFall;
  assign extHit = enabled & addrDone & ext_code(rxByte[7:4]);
  assign ownHit = enabled & addrDone & (rxByte[7:1] == ownSlaveAddress[7:1]);
  assign dirSet = enabled & (startGen | (addrDone & ~masterFlag_reg & rxByte[0]));
  assign dirClr = (addrDone & masterFlag_reg & rxByte[0])
    | (waitReleaseSet & inNinth & directionFlag_reg)
    | stopDet | releaseSet | enableFall;

  // no cpu write path reaches any of these
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      masterFlag_reg <= 1'b0;
    end else if (masterSet) begin
      masterFlag_reg <= 1'b1;
    end else if (masterClr) begin
      masterFlag_reg <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      arbLostFlag_reg <= 1'b0;
    end else if (enabled & arbLostEvt) begin
      arbLostFlag_reg <= 1'b1;
    end else if (statusRead | otherBitOp | enableFall) begin
      arbLostFlag_reg <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      extCodeFlag_reg <= 1'b0;
    end else if (extHit) begin
      extCodeFlag_reg <= 1'b1;
    end else if (frameClr) begin
      extCodeFlag_reg <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      addrMatchFlag_reg <= 1'b0;
    end else if (ownHit) begin
      addrMatchFlag_reg <= 1'b1;
    end else if (frameClr) begin
      addrMatchFlag_reg <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      directionFlag_reg <= 1'b0;
    end else if (dirSet) begin
      directionFlag_reg <= 1'b1;
    end else if (dirClr) begin
      directionFlag_reg <= 1'b0;
    end
  end

  // ==========================================================
  // data line drive, armed from the 9th clock fall of byte one
  logic driveArm_reg;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      driveArm_reg <= 1'b0;
    end else if (!directionFlag_reg | startDet | stopDet) begin
      driveArm_reg <= 1'b0;
    end else if (atNinth & sclFall) begin
      driveArm_reg <= 1'b1;
    end
  end

  // open drain: only a low is driven, a high floats
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      serialDataOut <= 1'b1;
    end else begin
      serialDataOut <= 1'b0;
    end
  end

  // registered enable: a cleared direction flag floats the line one
  // controller clock later, well inside the serial clock low phase
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      serialDataOe <= 1'b0;
    end else begin
      serialDataOe <= directionFlag_reg & driveArm_reg & ~shiftOutBit & enabled;
    end
  end

endmodule

// ---- tb/ssf_status_flags_assertions.sv ----
// port checks on the status flag block
`timescale 1ns/1ps
module ssf_status_flags_assertions
  import ssf_pkg::*;
(
  input wire logic clock, // clock
  input wire logic rst_n, // reset
  input wire logic serialClock, // link clock
  input wire logic serialDataIn, // data line
  input wire logic serialDataOut, // drive value
  input wire logic serialDataOe, // drive enable
  input wire ssf_cpu_req_t cpuReq, // cpu access
  input wire logic cpuWr, // write
  input wire logic [7:0] cpuRdData, // read data
  input wire logic [7:0] busControlReg, // control
  input wire logic [7:0] ownSlaveAddress, // own address
  input wire logic startGen, // start
  input wire logic arbLostEvt, // arb lost
  input wire logic shiftOutBit, // shift-out
  input wire ssf_status_t busStatus // status
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  logic rdHit;
  logic bitHit;
  logic en;
  assign rdHit = cpuReq.rd && !cpuWr && cpuReq.addr == BUS_STATUS_ADDR;
  assign bitHit = cpuReq.bitOp && cpuReq.addr == BUS_STATUS_ADDR && cpuReq.bitIdx != ARB_LOST_IDX;
  assign en = busControlReg[ENABLE_BIT];
  // ==========================================================
  // flag checks
  chk_reset_zero: assert property ($rose(rst_n) |-> busStatus == BUS_STATUS_RESET)
    else $error("status not zero after reset");
  chk_master_set: assert property (startGen && en |=> busStatus.master)
    else $error("start did not set master");
  chk_arb_set: assert property (arbLostEvt && en && !startGen |=> busStatus.arbLost && !busStatus.master)
    else $error("arbitration loss wrong");
  chk_read_clear: assert property (rdHit && !arbLostEvt |=> !busStatus.arbLost)
    else $error("read kept arb flag");
  chk_bit_clear: assert property (bitHit && !arbLostEvt |=> !busStatus.arbLost)
    else $error("bit op kept arb flag");
  chk_read_data: assert property (rdHit |=> cpuRdData == $past(busStatus))
    else $error("read data wrong");
  chk_enable_off: assert property ($fell(en) |=> busStatus == BUS_STATUS_RESET)
    else $error("disable left flags");
  chk_release_clr: assert property ($rose(busControlReg[RELEASE_BIT]) && !startGen
    |=> !busStatus.master && !busStatus.extCode && !busStatus.addrMatch)
    else $error("release left flags");
  chk_float_rx: assert property (!busStatus.direction [*3] |-> !serialDataOe)
    else $error("driving while receiving");
  chk_low_zero: assert property (busStatus.other == 3'h0)
    else $error("low bits set");
  cover property (busStatus.addrMatch);
  cover property (busStatus.arbLost);
  cover property (serialDataOe);
endmodule

// ---- tb/ssf_bus_partner.sv ----
// other master on the two-wire bus, open-drain
`timescale 1ns/1ps
module ssf_bus_partner (
  output logic serialClock, // clock line, idle high
  output logic sdaLow // pulls data line low
);
  initial begin
    serialClock = 1'b1;
    sdaLow = 1'b0;
  end
  // data released, so no start is seen
  task automatic idle_clocks(input int n);
    repeat (n) begin
      #16 serialClock = 1'b0;
      #16 serialClock = 1'b1;
    end
  endtask
  // start, address msb first, ninth clock; clock left low as a wait
  task automatic addr_byte(input logic [7:0] b);
    logic [8:0] s;
    s = {b, 1'b1};
    #16 sdaLow = 1'b1;
    repeat (9) begin
      #16 serialClock = 1'b0;
      #4 sdaLow = !s[8];
      s = s << 1;
      #12 serialClock = 1'b1;
    end
    #16 serialClock = 1'b0;
    #16;
  endtask
  task automatic stop_bus();
    #4 sdaLow = 1'b1;
    #12 serialClock = 1'b1;
    #16 sdaLow = 1'b0;
    #16;
  endtask
endmodule

// ---- tb/ssf_status_flags_bench.sv ----
// self-checking bench for the status flag block
`timescale 1ns/1ps
module ssf_status_flags_bench import ssf_pkg::*;;
  typedef struct packed {logic [7:0] adr; logic [7:0] st;} ssf_row_t;
  localparam ssf_row_t ROWS [5] = '{'{8'hA0, 8'h10}, '{8'hA1, 8'h18}, '{8'h08, 8'h20},
    '{8'hF3, 8'h28}, '{8'h55, 8'h08}};
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic serialClock, sdaLow, serialDataOut, serialDataOe, cpuWr, startGen, arbLostEvt, shiftOutBit;
  logic [7:0] cpuRdData, busControlReg, ownSlaveAddress;
  ssf_cpu_req_t cpuReq;
  ssf_status_t busStatus;
  wire serialDataIn = !(sdaLow || serialDataOe);
  int n_errors = 0;
  int checked = 0;
  always #2.5 clock = !clock;
  ssf_bus_partner partner (.serialClock, .sdaLow);
  ssf_status_flags dut (.clock, .rst_n, .serialClock, .serialDataIn, .serialDataOut, .serialDataOe,
    .cpuReq, .cpuWr, .cpuRdData, .busControlReg, .ownSlaveAddress, .startGen, .arbLostEvt,
    .shiftOutBit, .busStatus);
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clock);
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    cyc(1);
    s = 1'b0;
    cyc(1);
  endtask
  task automatic cpu(input logic rd, input logic bo, input logic [2:0] idx, input logic [15:0] a);
    cpuReq = '{a, rd, bo, idx};
    cyc(1);
    cpuReq = '0;
    cyc(1);
  endtask
  // link sampler needs a few link edges inside reset
  task automatic do_reset();
    rst_n = 1'b0;
    fork
      partner.idle_clocks(3);
      cyc(10);
    join
    cyc(1);
    rst_n = 1'b1;
    // the link sampler leaves reset only after two more serial clock rises
    partner.idle_clocks(2);
    cyc(2);
  endtask
  task automatic give_verdict();
    $display("errors %0d checks %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    #100000;
    n_errors++;
    give_verdict();
  end
  initial begin
    cpuReq = '0;
    cpuWr = 1'b0;
    startGen = 1'b0;
    arbLostEvt = 1'b0;
    shiftOutBit = 1'b1;
    busControlReg = 8'h00;
    ownSlaveAddress = 8'hA0;
    do_reset();
    chk("reset", busStatus, 8'h00);
    busControlReg = 8'h80;
    cyc(2);
    foreach (ROWS[i]) begin
      shiftOutBit = 1'b0;
      partner.addr_byte(ROWS[i].adr);
      cyc(8);
      chk("addr", busStatus, ROWS[i].st);
      chk("float", {7'h00, serialDataOe}, {7'h00, ROWS[i].st[DIRECTION_BIT]});
      shiftOutBit = 1'b1;
      cpu(1'b1, 1'b0, 3'h0, BUS_STATUS_ADDR);
      chk("read", cpuRdData, ROWS[i].st);
      partner.stop_bus();
      cyc(8);
      chk("stop", busStatus, 8'h00);
    end
    // ==========================================================
    // master, arbitration and cpu side clears
    pulse(startGen);
    chk("start", busStatus, 8'h88);
    pulse(arbLostEvt);
    chk("arb", busStatus, 8'h48);
    cpuWr = 1'b1;
    cpu(1'b1, 1'b0, 3'h0, BUS_STATUS_ADDR);
    cpuWr = 1'b0;
    chk("write", busStatus, 8'h48);
    cpu(1'b1, 1'b0, 3'h0, 16'hFF78);
    chk("unmapped", busStatus, 8'h48);
    cpu(1'b0, 1'b1, ARB_LOST_IDX, BUS_STATUS_ADDR);
    chk("own bit", busStatus, 8'h48);
    cpu(1'b0, 1'b1, 3'h3, BUS_STATUS_ADDR);
    chk("other bit", busStatus, 8'h08);
    pulse(arbLostEvt);
    cpu(1'b1, 1'b0, 3'h0, BUS_STATUS_ADDR);
    chk("rd data", cpuRdData, 8'h48);
    chk("rd clear", busStatus, 8'h08);
    pulse(startGen);
    busControlReg = 8'hC0;
    cyc(2);
    chk("release", busStatus, 8'h00);
    busControlReg = 8'h80;
    pulse(arbLostEvt);
    pulse(startGen);
    busControlReg = 8'h00;
    cyc(2);
    chk("disable", busStatus, 8'h00);
    // ==========================================================
    // master sends read bit, then slave transmit drive
    busControlReg = 8'h80;
    pulse(startGen);
    partner.addr_byte(8'h51);
    cyc(8);
    chk("master rx", {6'h00, busStatus.master, busStatus.direction}, 8'h02);
    partner.stop_bus();
    cyc(8);
    chk("master stop", busStatus, 8'h00);
    shiftOutBit = 1'b0;
    partner.addr_byte(8'hA1);
    cyc(8);
    chk("drive", {7'h00, serialDataOe}, 8'h01);
    chk("drive value", {7'h00, serialDataOut}, 8'h00);
    busControlReg = 8'hA0;
    cyc(8);
    chk("wait rel", {6'h00, busStatus.direction, serialDataOe}, 8'h00);
    busControlReg = 8'h80;
    partner.stop_bus();
    shiftOutBit = 1'b1;
    pulse(startGen);
    do_reset();
    chk("reset again", busStatus, 8'h00);
    chk("reset data", cpuRdData, 8'h00);
    give_verdict();
  end
endmodule
bind ssf_status_flags ssf_status_flags_assertions chk (.clock, .rst_n, .serialClock, .serialDataIn,
  .serialDataOut, .serialDataOe, .cpuReq, .cpuWr, .cpuRdData, .busControlReg, .ownSlaveAddress,
  .startGen, .arbLostEvt, .shiftOutBit, .busStatus);
